// ### lifm_cfg.svh
// Constants for the lift input function mapper: register offsets, field positions,
// reset values, selector codes and filter timing.
// Assumes inclusion by bare name from the package and the design modules.
//
// Summary of operation
// R1: Eight parallel control inputs command the drive.
// R2: Each input has reset function, reassignable.
// R3: Selector picks a preset or free assignment.
// R4: Parallel preset: enable, speeds, creep, up, down.
// R5: Changeable preset inputs accept reassignment; others fixed.
// R6: Binary preset: enable, direction, three-bit speed code.
// R7: Travel needs enable, speed and direction together.
// R8: Static jumper inverts polarity of all inputs.
// R9: Inputs synchronised and debounced before decoding.
`ifndef LIFM_CFG_SVH
`define LIFM_CFG_SVH

`define LIFM_NUM_INPUTS   8
`define LIFM_ADDR_W       4
`define LIFM_DATA_W       8

`define LIFM_OFF_CONFIG   4'h0
`define LIFM_OFF_LEVELS   4'h1
`define LIFM_OFF_STATUS   4'h2
`define LIFM_OFF_ASSIGN0  4'h8

`define LIFM_SEL_FREE     8'h00
`define LIFM_SEL_PARALLEL 8'h01
`define LIFM_SEL_BINARY   8'h0f
`define LIFM_SEL_RESET    8'h01

`define LIFM_ST_ENABLE    0
`define LIFM_ST_SPEED_LO  1
`define LIFM_ST_UP        4
`define LIFM_ST_DOWN      5
`define LIFM_ST_TRAVEL    6
`define LIFM_LV_JUMPER    0

`define LIFM_SPEED_NONE   3'h0
`define LIFM_SPEED_ONE    3'h1
`define LIFM_SPEED_TWO    3'h2
`define LIFM_SPEED_THREE  3'h3
`define LIFM_SPEED_CREEP  3'h7

`define LIFM_FILT_CYCLES  3'h4

`endif

// ### lifm_pkg.sv
// Types shared by the lift input function mapper modules.
// Assumes lifm_cfg.svh is on the include path.
`include "lifm_cfg.svh"

package lifm_pkg;

   typedef enum logic [3:0] {
      LIFM_FN_NONE                 = 4'h0,
      LIFM_FN_DRIVE_ENABLE_INPUT   = 4'h1,
      LIFM_FN_SPEED_SELECT_ONE     = 4'h2,
      LIFM_FN_SPEED_SELECT_TWO     = 4'h3,
      LIFM_FN_SPEED_SELECT_THREE   = 4'h4,
      LIFM_FN_CREEP_SPEED_SELECT   = 4'h5,
      LIFM_FN_UP_DIRECTION_INPUT   = 4'h6,
      LIFM_FN_DOWN_DIRECTION_INPUT = 4'h7,
      LIFM_FN_DIRECTION            = 4'h8,
      LIFM_FN_SPEED_CODE_BIT0      = 4'h9,
      LIFM_FN_SPEED_CODE_BIT1      = 4'ha,
      LIFM_FN_SPEED_CODE_BIT2      = 4'hb
   } lifm_func_t;

   typedef struct packed {
      logic [7:0]      s1;
      logic [7:0]      s2;
      logic [7:0][2:0] cnt;
      logic [7:0]      stable;
   } lifm_filt_state_t;

   typedef struct packed {
      logic [7:0]       cfg_sel;
      lifm_func_t [7:0] fn_store;
      logic             inv_s1;
      logic             inv_s2;
      logic [7:0]       rdata;
      logic             enable;
      logic [2:0]       speed;
      logic             up;
      logic             down;
      logic             travel;
   } lifm_top_state_t;

endpackage

// ### lifm_input_filter.sv
// Two-flop synchroniser and per-bit debounce filter for the eight control inputs.
// Assumes inputs are relay or contact driven and may bounce for a few cycles.
`timescale 1ns/1ns
`include "lifm_cfg.svh"

module lifm_input_filter
   import lifm_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic [7:0] raw_in,
   output logic      [7:0] filtered
);

   lifm_filt_state_t st_q;
   lifm_filt_state_t st_d;
   logic [7:0][2:0]  cnt_nx;
   logic [7:0]       stb_nx;

   // R9: debounce per input
   genvar i;
   generate
      for (i = 0; i < `LIFM_NUM_INPUTS; i++) begin : g_bit
         always_comb begin
            cnt_nx[i] = 3'h0;
            stb_nx[i] = st_q.stable[i];
            if (st_q.s2[i] != st_q.stable[i]) begin
               if (st_q.cnt[i] == `LIFM_FILT_CYCLES - 3'h1) begin
                  stb_nx[i] = st_q.s2[i];
               end else begin
                  cnt_nx[i] = st_q.cnt[i] + 3'h1;
               end
            end
         end
      end
   endgenerate

   // R9: two-flop synchroniser
   always_comb begin
      st_d        = st_q;
      st_d.s1     = raw_in;
      st_d.s2     = st_q.s1;
      st_d.cnt    = cnt_nx;
      st_d.stable = stb_nx;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign filtered = st_q.stable;

endmodule

// ### lifm_mapper.sv
// Lift input function mapper: maps eight filtered control inputs to drive functions
// according to the selected preset or free assignment, and decodes travel commands.
// Assumes inputs asynchronous to core_clk and a register master that never overlaps strobes.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`include "lifm_cfg.svh"

module lifm_mapper
   import lifm_pkg::*;
(
   input  wire logic                    core_clk,
   input  wire logic                    nrst,
   input  wire logic [7:0]              input_lines,
   input  wire logic                    polarity_jumper,
   input  wire logic [`LIFM_ADDR_W-1:0] reg_addr,
   input  wire logic [`LIFM_DATA_W-1:0] reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [`LIFM_DATA_W-1:0] reg_rdata,
   output logic                         drive_enable,
   output logic      [2:0]              speed_select,
   output logic                         up_direction,
   output logic                         down_direction,
   output logic                         travel_request
);

   lifm_top_state_t  st_q;
   lifm_top_state_t  st_d;
   logic [7:0]       filt;
   logic [7:0]       level;
   lifm_func_t [7:0] eff_fn;
   logic [7:0][15:0] hit_vec;
   logic [15:0]      hits;
   logic [2:0]       par_speed;
   logic [2:0]       bin_speed;
   logic             sel_binary;
   logic             cfg_wr;
   logic             asg_wr;
   logic             sel_ok;
   logic [7:0]       status_byte;

   // R1: eight input lines
   // R9: synchronise and debounce
   lifm_input_filter u_filter (
      .core_clk (core_clk),
      .nrst     (nrst),
      .raw_in   (input_lines),
      .filtered (filt)
   );

   // The strap is static, yet it passes two flops so moving it live cannot tear a decode.
   // R8: jumper inverts polarity
   assign level = filt ^ {8{st_q.inv_s2}};

   genvar i;
   generate
      for (i = 0; i < `LIFM_NUM_INPUTS; i++) begin : g_map
         always_comb begin
            eff_fn[i] = st_q.fn_store[i];
            unique case (st_q.cfg_sel)
               // R4: parallel preset table
               // R5: only input eight changeable
               `LIFM_SEL_PARALLEL: begin
                  if (i != 7) begin
                     eff_fn[i] = lifm_func_t'(4'(i + 1));
                  end
               end
               // R6: binary preset table
               // R5: only input eight changeable
               `LIFM_SEL_BINARY: begin
                  if (i == 0) begin
                     eff_fn[i] = LIFM_FN_DRIVE_ENABLE_INPUT;
                  end else if (i == 1) begin
                     eff_fn[i] = LIFM_FN_DIRECTION;
                  end else if (i < 5) begin
                     eff_fn[i] = lifm_func_t'(4'(i + 7));
                  end else if (i < 7) begin
                     eff_fn[i] = LIFM_FN_NONE;
                  end
               end
               // R3: free assignment uses stored functions
               default: begin
                  eff_fn[i] = st_q.fn_store[i];
               end
            endcase
            hit_vec[i] = level[i] ? (16'h0001 << eff_fn[i]) : 16'h0000;
         end
      end
   endgenerate

   // Several inputs may carry one function; any active one asserts it.
   always_comb begin
      hits = 16'h0000;
      for (int k = 0; k < `LIFM_NUM_INPUTS; k++) begin
         hits = hits | hit_vec[k];
      end
   end

   // Highest speed wins if the control raises several lines, creep only when alone.
   always_comb begin
      if (hits[LIFM_FN_SPEED_SELECT_THREE]) begin
         par_speed = `LIFM_SPEED_THREE;
      end else if (hits[LIFM_FN_SPEED_SELECT_TWO]) begin
         par_speed = `LIFM_SPEED_TWO;
      end else if (hits[LIFM_FN_SPEED_SELECT_ONE]) begin
         par_speed = `LIFM_SPEED_ONE;
      end else if (hits[LIFM_FN_CREEP_SPEED_SELECT]) begin
         par_speed = `LIFM_SPEED_CREEP;
      end else begin
         par_speed = `LIFM_SPEED_NONE;
      end
   end

   // R6: binary speed code
   assign bin_speed = {hits[LIFM_FN_SPEED_CODE_BIT2],
                       hits[LIFM_FN_SPEED_CODE_BIT1],
                       hits[LIFM_FN_SPEED_CODE_BIT0]};

   // In the binary preset one line carries the direction, so up and down are never both idle.
   assign sel_binary = (st_q.cfg_sel == `LIFM_SEL_BINARY);

   // R3: selector write decode
   // Only the free, parallel and binary selector codes are accepted; any other code would leave some inputs
   // without a defined function, so such a write is dropped rather than stored.
   assign cfg_wr = reg_wr && (reg_addr == `LIFM_OFF_CONFIG);
   assign sel_ok = (reg_wdata == `LIFM_SEL_FREE) ||
                   (reg_wdata == `LIFM_SEL_PARALLEL) ||
                   (reg_wdata == `LIFM_SEL_BINARY);

   // R2: assign write decode
   // Writes to an assignment are always stored, even under a preset, so that a later
   // switch to free assignment picks up what software wrote.
   assign asg_wr = reg_wr && (reg_addr >= `LIFM_OFF_ASSIGN0);

   // Status word as software sees it; bit seven echoes the synchronised jumper.
   always_comb begin
      status_byte                                        = 8'h00;
      status_byte[`LIFM_ST_ENABLE]                       = st_q.enable;
      status_byte[`LIFM_ST_SPEED_LO+2:`LIFM_ST_SPEED_LO] = st_q.speed;
      status_byte[`LIFM_ST_UP]                           = st_q.up;
      status_byte[`LIFM_ST_DOWN]                         = st_q.down;
      status_byte[`LIFM_ST_TRAVEL]                       = st_q.travel;
      status_byte[7]                                     = st_q.inv_s2;
   end

   always_comb begin
      st_d        = st_q;
      st_d.inv_s1 = polarity_jumper;
      st_d.inv_s2 = st_q.inv_s1;
      st_d.rdata  = '0;

      // R3: configuration selector write
      if (cfg_wr && sel_ok) begin
         st_d.cfg_sel = reg_wdata;
      end
      // R2: stored function reassignment
      if (asg_wr) begin
         st_d.fn_store[reg_addr[2:0]] = lifm_func_t'(reg_wdata[3:0]);
      end

      // Read data stand for one cycle and are zero otherwise, so no old value lingers.
      if (reg_rd) begin
         unique case (reg_addr)
            `LIFM_OFF_CONFIG: begin
               st_d.rdata = st_q.cfg_sel;
            end
            `LIFM_OFF_LEVELS: begin
               st_d.rdata = level;
            end
            `LIFM_OFF_STATUS: begin
               st_d.rdata = status_byte;
            end
            default: begin
               // Holes below the assignment block read as zero.
               if (reg_addr >= `LIFM_OFF_ASSIGN0) begin
                  st_d.rdata = {4'h0, eff_fn[reg_addr[2:0]]};
               end
            end
         endcase
      end

      st_d.enable = hits[LIFM_FN_DRIVE_ENABLE_INPUT];
      if (sel_binary) begin
         st_d.speed = bin_speed;
         st_d.up    = hits[LIFM_FN_DIRECTION];
         st_d.down  = !hits[LIFM_FN_DIRECTION];
      end else begin
         st_d.speed = par_speed;
         st_d.up    = hits[LIFM_FN_UP_DIRECTION_INPUT];
         st_d.down  = hits[LIFM_FN_DOWN_DIRECTION_INPUT];
      end
      // Up and down together contradict each other, so travel is withheld then.
      // R7: travel needs all three
      st_d.travel = st_d.enable && (st_d.speed != `LIFM_SPEED_NONE) &&
                    (st_d.up ^ st_d.down);
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_q          <= '0;
         st_q.cfg_sel  <= `LIFM_SEL_RESET;
         // R2: reset functions of each input
         st_q.fn_store[0] <= LIFM_FN_DRIVE_ENABLE_INPUT;
         st_q.fn_store[1] <= LIFM_FN_SPEED_SELECT_ONE;
         st_q.fn_store[2] <= LIFM_FN_SPEED_SELECT_TWO;
         st_q.fn_store[3] <= LIFM_FN_SPEED_SELECT_THREE;
         st_q.fn_store[4] <= LIFM_FN_CREEP_SPEED_SELECT;
         st_q.fn_store[5] <= LIFM_FN_UP_DIRECTION_INPUT;
         st_q.fn_store[6] <= LIFM_FN_DOWN_DIRECTION_INPUT;
         st_q.fn_store[7] <= LIFM_FN_NONE;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs leave straight from registers so the far side never sees decode glitches.
   assign reg_rdata      = st_q.rdata;
   assign drive_enable   = st_q.enable;
   assign speed_select   = st_q.speed;
   assign up_direction   = st_q.up;
   assign down_direction = st_q.down;
   assign travel_request = st_q.travel;

endmodule

// ### lifm_mapper_props.sv
// Port checker for the lift input mapper.
// Assumes the mapper's seven-cycle input latency and one-cycle read data.
`timescale 1ns/1ns
module lifm_mapper_props (
   input wire logic       core_clk,
   input wire logic       nrst,
   input wire logic [7:0] input_lines,
   input wire logic       polarity_jumper,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       drive_enable,
   input wire logic [2:0] speed_select,
   input wire logic       up_direction,
   input wire logic       down_direction,
   input wire logic       travel_request
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic [7:0] prev_q;
   logic       pj_q;
   logic [3:0] quiet_q;
   // Quiet span must outlast filter and decode, so only settled outputs are judged.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prev_q  <= 8'h00;
         pj_q    <= 1'b0;
         quiet_q <= 4'h0;
      end else begin
         prev_q  <= input_lines;
         pj_q    <= polarity_jumper;
         if (input_lines != prev_q || polarity_jumper != pj_q || reg_wr)
            quiet_q <= 4'h0;
         else if (quiet_q != 4'hf)
            quiet_q <= quiet_q + 4'h1;
      end
   end
   sequence s_cfg_wr(v);
      reg_wr && reg_addr == 4'h0 && reg_wdata == v;
   endsequence
   sequence s_cfg_rd;
      reg_rd && reg_addr == 4'h0;
   endsequence
   a_rdata_idle_zero: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
      else $error("read data outside its slot");
   a_travel_needs_all: assert property (travel_request |-> drive_enable &&
      speed_select != 3'h0 && (up_direction ^ down_direction))
      else $error("travel without enable, speed and one direction");
   a_travel_when_all: assert property (drive_enable && speed_select != 3'h0 &&
      (up_direction ^ down_direction) |-> travel_request)
      else $error("travel missing with all commands present");
   a_cfg_readback: assert property (s_cfg_wr(8'h0f) ##1 s_cfg_rd |=> reg_rdata == 8'h0f)
      else $error("selector not read back");
   a_cfg_refuse: assert property (
      s_cfg_wr(8'h0f) ##1 s_cfg_wr(8'h05) ##1 s_cfg_rd |=> reg_rdata == 8'h0f)
      else $error("invalid selector value taken");
   a_unmapped_zero: assert property (reg_rd && reg_addr inside {[4'h3:4'h7]}
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_levels_follow: assert property (quiet_q >= 4'ha && reg_rd && reg_addr == 4'h1
      |=> reg_rdata == ($past(input_lines) ^ {8{$past(polarity_jumper)}}))
      else $error("levels differ from settled inputs");
   a_outputs_settle: assert property (quiet_q >= 4'ha |-> $stable({drive_enable,
      speed_select, up_direction, down_direction, travel_request}))
      else $error("outputs move with quiet inputs");
endmodule
bind lifm_mapper lifm_mapper_props u_props (.core_clk(core_clk), .nrst(nrst),
   .input_lines(input_lines), .polarity_jumper(polarity_jumper), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .drive_enable(drive_enable), .speed_select(speed_select), .up_direction(up_direction),
   .down_direction(down_direction), .travel_request(travel_request));

// ### lifm_lift_model.sv
// Lift control model: drives the eight command lines from a command word.
// Assumes the bench changes the command just after a rising edge.
`timescale 1ns/1ns
module lifm_lift_model (
   input  wire logic       core_clk,
   input  wire logic [7:0] cmd,
   input  wire logic       bouncy,
   output logic      [7:0] input_lines
);
   logic [7:0] cur_q = 8'h00;
   logic [7:0] old_q = 8'h00;
   logic [1:0] ph_q  = 2'h0;
   // whole command word lands at one edge
   always @(posedge core_clk) begin
      if (cmd != cur_q) begin
         old_q <= cur_q;
         cur_q <= cmd;
         ph_q  <= bouncy ? 2'h3 : 2'h0;
      end else if (ph_q != 2'h0) begin
         ph_q <= ph_q - 2'h1;
      end
   end
   // relay contacts fall back once before settling
   assign input_lines = (ph_q == 2'h1) ? old_q : cur_q;
endmodule

// ### tb.sv
// Bench for the lift input mapper: register access and command-line scenarios.
// Assumes the lift control model on the inputs and the bound port checker.
`timescale 1ns/1ns
module tb;
   logic       core_clk = 1'b0;
   logic       nrst = 1'b0;
   logic [7:0] cmd = 8'h00;
   logic       bouncy = 1'b0;
   logic       polarity_jumper = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] input_lines, reg_rdata, d;
   logic       drive_enable, up_direction, down_direction, travel_request;
   logic [2:0] speed_select;
   wire  [6:0] outs = {drive_enable, speed_select, up_direction, down_direction, travel_request};
   int         fail_count = 0;
   int         num_checks = 0;
   int         i;
   logic [7:0] rst_fn [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h00};
   logic [7:0] par_in [6] = '{8'h23, 8'h4d, 8'h51, 8'h63, 8'h22, 8'h21};
   logic [6:0] par_exp [6] = '{7'h4d, 7'h5b, 7'h7b, 7'h4e, 7'h0c, 7'h44};

   lifm_lift_model mdl (.core_clk(core_clk), .cmd(cmd), .bouncy(bouncy),
      .input_lines(input_lines));
   lifm_mapper dut (.core_clk(core_clk), .nrst(nrst), .input_lines(input_lines),
      .polarity_jumper(polarity_jumper), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drive_enable(drive_enable),
      .speed_select(speed_select), .up_direction(up_direction),
      .down_direction(down_direction), .travel_request(travel_request));

   initial begin
      forever #25 core_clk = ~core_clk;
   end

   task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_out(input string what, input logic [6:0] exp, input logic [6:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Writes leave the strobe up so a following access can run back to back.
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_rd    <= 1'b0;
      reg_addr  <= a;
      reg_wdata <= v;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge core_clk);
      reg_wr   <= 1'b0;
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      v = reg_rdata;
   endtask
   task automatic apply(input logic [7:0] c, input logic [6:0] exp);
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      cmd    <= c;
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      chk_out("outputs", exp, outs);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      #(50 * 4000);
      fail_count++;
      tally_and_finish();
   end

   initial begin
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      rd(4'h0, d);
      chk_reg("selector", 8'h01, d);
      for (i = 0; i < 8; i++) begin
         rd(4'h8 + 4'(i), d);
         chk_reg("assign", rst_fn[i], d);
      end
      $display("reset test done");
      for (i = 0; i < 6; i++) apply(par_in[i], par_exp[i]);
      apply(8'h00, 7'h00);
      @(posedge core_clk);
      cmd <= 8'h23;
      for (i = 0; i < 12; i++) begin
         @(posedge core_clk);
         if (i == 1) cmd <= 8'h00;
         @(negedge core_clk);
         chk_out("glitch", 7'h00, outs);
      end
      bouncy <= 1'b1;
      apply(8'h23, 7'h4d);
      $display("parallel test done");
      wr(4'h8, 8'h07);
      wr(4'hf, 8'h02);
      rd(4'h8, d);
      chk_reg("fixed input", 8'h01, d);
      rd(4'hf, d);
      chk_reg("free input", 8'h02, d);
      apply(8'ha1, 7'h4d);
      rd(4'h2, d);
      chk_reg("status", 8'h53, d);
      rd(4'h1, d);
      chk_reg("levels", 8'ha1, d);
      rd(4'h5, d);
      chk_reg("unmapped", 8'h00, d);
      $display("assign test done");
      wr(4'h0, 8'h0f);
      rd(4'h0, d);
      chk_reg("selector", 8'h0f, d);
      wr(4'h0, 8'h0f);
      wr(4'h0, 8'h05);
      rd(4'h0, d);
      chk_reg("selector", 8'h0f, d);
      rd(4'h9, d);
      chk_reg("direction input", 8'h08, d);
      for (i = 0; i < 8; i++)
         apply({3'h0, 3'(i), 1'(i % 2), 1'b1}, {1'b1, 3'(i), 1'(i % 2), 1'(1 - i % 2), 1'(i != 0)});
      $display("binary test done");
      wr(4'h0, 8'h00);
      apply(8'h81, 7'h0a);
      wr(4'h8, 8'h01);
      apply(8'ha3, 7'h4d);
      $display("free test done");
      @(posedge core_clk);
      polarity_jumper <= 1'b1;
      apply(8'h5c, 7'h4d);
      rd(4'h1, d);
      chk_reg("levels", 8'ha3, d);
      rd(4'h2, d);
      chk_reg("status", 8'hd3, d);
      $display("polarity test done");
      tally_and_finish();
   end
endmodule
